// ---- fusp_defines.svh ----
// Purpose: Constants of the flash user program sequencer
// Assumes: Byte-wide register port, 125 MHz system clock
// Notes: Included by the sequencer only; the package does not include it
//
// Contract
// - Erase, program and lock accepted only while unlock key holds A5; zero disables.
// - Erase failure reported in control bit 3; nonzero means failed, host repeats.
// - Program writes one byte per store, only into erased locations.
// - Store starts programming; at most 128 bytes per loaded sector address.
// - Table load returns flash byte at 16-bit address; no key or setup needed.
// - Writing 0110 to control upper nibble sets hard lock, refusing writes, sector erases.
// - Hard lock cleared only by chip erase or reset.
// - Control bit 0 triggers erase and hard lock; reads and programs ignore it.
// - Interrupt during sector erase abandons it and leaves status bit at 1.
// - Sector erase lasts at least 10 ms after trigger.
// - Sectors are 128 bytes; low seven sector-low bits ignored.
`ifndef FUSP_DEFINES_SVH
`define FUSP_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FUSP_OFF_KEY 2'h0
`define FUSP_OFF_CTRL 2'h1
`define FUSP_OFF_SECH 2'h2
`define FUSP_OFF_SECL 2'h3

// ----------------------------------------
// Codes and fields
// ----------------------------------------
`define FUSP_KEY_OPEN 8'hA5
`define FUSP_KEY_RST 8'h00
`define FUSP_MODE_ERASE 4'hA
`define FUSP_MODE_PROG 4'h5
`define FUSP_MODE_LOCK 4'h6
`define FUSP_MODE_CHIP 4'h8
`define FUSP_CTRL_START 0
`define FUSP_CTRL_FAIL 3
`define FUSP_ERASED 8'hFF
`define FUSP_SECTOR_BYTES 8'h80

// ----------------------------------------
// Timing
// ----------------------------------------
`define FUSP_ERASE_MS 10
`define FUSP_CLK_KHZ 125000

`endif

// ---- fusp_pkg.sv ----
// Purpose: Types of the flash user program sequencer
// Assumes: Header constants are not included here
// Notes: State is one packed struct
package fusp_pkg;
	typedef enum logic [2:0] {
		FUSP_IDLE = 3'b001,
		FUSP_WAIT = 3'b010,
		FUSP_FILL = 3'b100
	} fusp_state_t;

	typedef struct packed {
		fusp_state_t state;
		logic [7:0] key;
		logic [3:0] mode;
		logic fail;
		logic [7:0] sec_hi;
		logic sec_lo7;
		logic [7:0] prog_cnt;
		logic lock;
		logic is_chip;
		logic [15:0] idx;
		logic [20:0] timer;
		logic [7:0] reg_rdata;
		logic busy;
	} fusp_regs_t;
endpackage

// ---- fusp_sequencer.sv ----
// Purpose: User-mode flash erase, program, read and hard-lock sequencer
// Assumes: Synchronous inputs, byte register port, table port from CPU
// Notes: Flash array is modelled inside; erase writes FF byte by byte
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "fusp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fusp_sequencer #(
	parameter int ERASE_CYCLES = `FUSP_ERASE_MS * `FUSP_CLK_KHZ
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] tbl_addr,
	input wire logic [7:0] tbl_wdata,
	input wire logic tbl_store,
	input wire logic tbl_load,
	output logic [7:0] tbl_rdata,
	input wire logic irq_req,
	output logic busy,
	output logic hard_locked,
	output logic erase_failed
);
	import fusp_pkg::*;

	localparam logic [20:0] ERASE_LAST = 21'(ERASE_CYCLES - 1);

	fusp_regs_t cur_ff;
	fusp_regs_t nxt_cur;
	logic [7:0] mem [0:65535];
	logic [7:0] tbl_rdata_ff;
	logic mem_we;
	logic [15:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic key_open;
	logic [15:0] sec_base;
	logic in_sector;
	logic prog_ok;
	logic ctrl_wr;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	assign key_open = (cur_ff.key == `FUSP_KEY_OPEN);
	assign sec_base = {cur_ff.sec_hi, cur_ff.sec_lo7, 7'h00};
	assign in_sector = (tbl_addr[15:7] == sec_base[15:7]);
	assign ctrl_wr = reg_wr && (reg_addr == `FUSP_OFF_CTRL);
	assign prog_ok = tbl_store && key_open && !cur_ff.busy
		&& (cur_ff.mode == `FUSP_MODE_PROG) && !cur_ff.lock
		&& in_sector && (cur_ff.prog_cnt < `FUSP_SECTOR_BYTES)
		&& (mem[tbl_addr] == `FUSP_ERASED);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_cur = cur_ff;
		mem_we = 1'b0;
		mem_waddr = tbl_addr;
		mem_wdata = tbl_wdata;

		// Register reads
		if (reg_rd) begin
			unique case (reg_addr)
				`FUSP_OFF_KEY: nxt_cur.reg_rdata = cur_ff.key;
				`FUSP_OFF_CTRL: nxt_cur.reg_rdata = {cur_ff.mode, cur_ff.fail, 3'h0};
				`FUSP_OFF_SECH: nxt_cur.reg_rdata = cur_ff.sec_hi;
				`FUSP_OFF_SECL: nxt_cur.reg_rdata = {cur_ff.sec_lo7, 7'h00};
			endcase
		end

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				`FUSP_OFF_KEY: nxt_cur.key = reg_wdata;
				`FUSP_OFF_SECH: begin
					nxt_cur.sec_hi = reg_wdata;
					nxt_cur.prog_cnt = 8'h00;
				end
				`FUSP_OFF_SECL: begin
					nxt_cur.sec_lo7 = reg_wdata[7];
					nxt_cur.prog_cnt = 8'h00;
				end
				`FUSP_OFF_CTRL: begin
					if (!cur_ff.busy) begin
						nxt_cur.mode = reg_wdata[7:4];
					end
				end
			endcase
		end

		// Triggers from control bit 0
		if (ctrl_wr && !cur_ff.busy && reg_wdata[`FUSP_CTRL_START]
			&& key_open) begin
			unique case (reg_wdata[7:4])
				`FUSP_MODE_ERASE: begin
					nxt_cur.fail = 1'b1;
					if (!cur_ff.lock) begin
						nxt_cur.state = FUSP_WAIT;
						nxt_cur.busy = 1'b1;
						nxt_cur.is_chip = 1'b0;
						nxt_cur.timer = 21'h000000;
						nxt_cur.idx = sec_base;
					end
				end
				`FUSP_MODE_LOCK: nxt_cur.lock = 1'b1;
				`FUSP_MODE_CHIP: begin
					nxt_cur.state = FUSP_FILL;
					nxt_cur.busy = 1'b1;
					nxt_cur.is_chip = 1'b1;
					nxt_cur.idx = 16'h0000;
				end
				default: begin
				end
			endcase
		end

		// Byte program from table store
		if (prog_ok) begin
			mem_we = 1'b1;
			nxt_cur.prog_cnt = cur_ff.prog_cnt + 8'h01;
		end

		// Erase sequencing
		unique case (cur_ff.state)
			FUSP_IDLE: begin
			end
			FUSP_WAIT: begin
				if (irq_req) begin
					nxt_cur.state = FUSP_IDLE;
					nxt_cur.busy = 1'b0;
				end else if (cur_ff.timer >= ERASE_LAST) begin
					nxt_cur.state = FUSP_FILL;
				end else begin
					nxt_cur.timer = cur_ff.timer + 21'h000001;
				end
			end
			FUSP_FILL: begin
				if (irq_req && !cur_ff.is_chip) begin
					nxt_cur.state = FUSP_IDLE;
					nxt_cur.busy = 1'b0;
				end else begin
					mem_we = 1'b1;
					mem_waddr = cur_ff.idx;
					mem_wdata = `FUSP_ERASED;
					nxt_cur.idx = cur_ff.idx + 16'h0001;
					if (cur_ff.is_chip ? (cur_ff.idx == 16'hFFFF)
						: (cur_ff.idx[6:0] == 7'h7F)) begin
						nxt_cur.state = FUSP_IDLE;
						nxt_cur.busy = 1'b0;
						nxt_cur.fail = 1'b0;
						if (cur_ff.is_chip) begin
							nxt_cur.lock = 1'b0;
						end
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cur_ff <= '0;
			cur_ff.state <= FUSP_IDLE;
			cur_ff.key <= `FUSP_KEY_RST;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------
	// Flash array and table read
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
		if (!resetn) begin
			tbl_rdata_ff <= 8'h00;
		end else if (tbl_load) begin
			tbl_rdata_ff <= mem[tbl_addr];
		end
	end

	assign reg_rdata = cur_ff.reg_rdata;
	assign tbl_rdata = tbl_rdata_ff;
	assign busy = cur_ff.busy;
	assign hard_locked = cur_ff.lock;
	assign erase_failed = cur_ff.fail;
endmodule

`default_nettype wire

// ---- fusp_sequencer_asserts.sv ----
// Purpose: Port-level checks of the flash sequencer
// Assumes: Register index 0 is the key, 1 the control
// Notes: Key state is tracked from observed writes
`timescale 1ns/1ps
`default_nettype none
module fusp_sequencer_asserts #(
	parameter int ERASE_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic irq_req,
	input wire logic busy,
	input wire logic hard_locked,
	input wire logic erase_failed
);
	logic key_ok_ff;
	logic [23:0] cnt_ff;
	wire logic ctl_wr = reg_wr && reg_addr == 2'h1 && !busy;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			key_ok_ff <= 1'b0;
			cnt_ff <= 24'h000000;
		end else begin
			if (reg_wr && reg_addr == 2'h0) begin
				key_ok_ff <= reg_wdata == 8'hA5;
			end
			cnt_ff <= busy ? cnt_ff + 24'h000001 : 24'h000000;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_erase_trig;
		ctl_wr && reg_wdata == 8'hA1 && key_ok_ff && !hard_locked;
	endsequence
	a_erase_start: assert property (s_erase_trig |=> busy && erase_failed)
		else $error("erase did not start");
	a_need_key: assert property (ctl_wr && !key_ok_ff |=> !busy)
		else $error("trigger taken without key");
	a_need_start: assert property (ctl_wr && !reg_wdata[0] |=> !busy)
		else $error("trigger taken without start bit");
	a_lock_set: assert property (ctl_wr && reg_wdata == 8'h61 && key_ok_ff
		|=> hard_locked)
		else $error("lock not set");
	a_lock_refuse: assert property (hard_locked && ctl_wr && reg_wdata[0]
		&& reg_wdata[7:4] == 4'hA |=> !busy && erase_failed)
		else $error("erase ran while locked");
	a_irq_abort: assert property (s_erase_trig ##2 irq_req
		|=> !busy && erase_failed)
		else $error("erase not abandoned");
	a_erase_time: assert property ($fell(busy) && !$past(irq_req)
		|-> cnt_ff >= ERASE_CYCLES + 128)
		else $error("erase too short");
	a_erase_end: assert property ($fell(busy) && !$past(irq_req)
		|-> !erase_failed && !hard_locked)
		else $error("bad status after erase");
	a_lock_hold: assert property (hard_locked && !busy |=> hard_locked)
		else $error("lock dropped");
endmodule
bind fusp_sequencer fusp_sequencer_asserts #(.ERASE_CYCLES(ERASE_CYCLES))
	u_chk (.*);
`default_nettype wire

// ---- fusp_host_model.sv ----
// Purpose: Host core model for register and table cycles
// Assumes: Signals change just after the rising edge
// Notes: Idle data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module fusp_host_model (
	input wire logic sys_clk,
	output logic [1:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] tbl_addr,
	output logic [7:0] tbl_wdata,
	output logic tbl_store,
	output logic tbl_load
);
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, tbl_addr, tbl_wdata} = '0;
		{tbl_store, tbl_load} = 2'h0;
	end
	task automatic cyc(input logic [3:0] s);
		{reg_wr, reg_rd, tbl_store, tbl_load} <= s;
		@(posedge sys_clk);
		{reg_wr, reg_rd, tbl_store, tbl_load} <= 4'h0;
		reg_wdata <= ~reg_wdata;
		tbl_wdata <= ~tbl_wdata;
		@(posedge sys_clk);
	endtask
	task automatic w(input logic [1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		cyc(4'h8);
	endtask
	task automatic r(input logic [1:0] a);
		reg_addr <= a;
		cyc(4'h4);
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] d);
		tbl_addr <= a;
		tbl_wdata <= d;
		cyc(4'h2);
	endtask
	task automatic ld(input logic [15:0] a);
		tbl_addr <= a;
		cyc(4'h1);
	endtask
endmodule
`default_nettype wire

// ---- tb_flash_user_program_sequencer.sv ----
// Purpose: Self-checking bench of the flash sequencer
// Assumes: Host model drives all bus inputs
// Notes: Read results are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_flash_user_program_sequencer;
	import fusp_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic irq_req = 1'b0;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, tbl_wdata, tbl_rdata;
	logic [15:0] tbl_addr;
	logic reg_wr, reg_rd, tbl_store, tbl_load, busy, hard_locked, erase_failed;
	logic pend = 1'b0;
	logic sel = 1'b0;
	logic [7:0] exp_q[$];
	logic [31:0] rnd = 32'hDC84;
	int failures = 0;
	int tests_run = 0;
	fusp_sequencer #(.ERASE_CYCLES(20)) u_fusp_sequencer (.*);
	fusp_host_model u_fusp_host_model (.*);
	always #4 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_idle(input int n);
		for (int i = 0; i < n && busy !== 1'b0; i++) @(negedge sys_clk);
		@(posedge sys_clk);
		if (busy !== 1'b0) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic rc(input logic [1:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_fusp_host_model.r(a);
	endtask
	task automatic lc(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_fusp_host_model.ld(a);
	endtask
	always @(posedge sys_clk) begin
		pend <= reg_rd | tbl_load;
		sel <= reg_rd;
	end
	always @(negedge sys_clk) begin
		if (pend === 1'b1) check(sel ? reg_rdata : tbl_rdata, exp_q.pop_front());
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		u_fusp_host_model.w(2'h0, 8'hA5);
		u_fusp_host_model.w(2'h2, 8'h18);
		u_fusp_host_model.w(2'h3, 8'h7F);
		u_fusp_host_model.w(2'h1, 8'hA1);
		u_fusp_host_model.w(2'h0, 8'h00);
		wait_idle(300);
		rc(2'h1, 8'hA0);
		rc(2'h3, 8'h00);
		rc(2'h2, 8'h18);
		rc(2'h0, 8'h00);
		lc(16'h187F, 8'hFF);
		$display("sector erase done");
		u_fusp_host_model.w(2'h1, 8'h51);
		u_fusp_host_model.st(16'h1803, 8'h3C);
		lc(16'h1803, 8'hFF);
		u_fusp_host_model.w(2'h0, 8'hA5);
		u_fusp_host_model.w(2'h1, 8'hA0);
		u_fusp_host_model.w(2'h1, 8'h51);
		u_fusp_host_model.w(2'h3, 8'h01);
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			u_fusp_host_model.st(16'h1800 | 16'(i), {1'b0, rnd[6:0]});
			lc(16'h1800 | 16'(i), {1'b0, rnd[6:0]});
		end
		u_fusp_host_model.st(16'h1803, {1'b1, ~rnd[6:0]});
		lc(16'h1803, {1'b0, rnd[6:0]});
		$display("program done");
		u_fusp_host_model.w(2'h1, 8'hA1);
		irq_req <= 1'b1;
		@(posedge sys_clk);
		irq_req <= 1'b0;
		wait_idle(300);
		rc(2'h1, 8'hA8);
		u_fusp_host_model.w(2'h1, 8'hA1);
		wait_idle(300);
		rc(2'h1, 8'hA0);
		$display("abort done");
		u_fusp_host_model.w(2'h1, 8'h61);
		check({7'h00, hard_locked}, 8'h01);
		u_fusp_host_model.w(2'h1, 8'h51);
		u_fusp_host_model.st(16'h1810, 8'h5A);
		lc(16'h1810, 8'hFF);
		u_fusp_host_model.w(2'h1, 8'hA1);
		rc(2'h1, 8'hA8);
		$display("lock done");
		u_fusp_host_model.w(2'h1, 8'h81);
		wait_idle(70000);
		check({6'h00, hard_locked, erase_failed}, 8'h00);
		lc(16'h1803, 8'hFF);
		$display("chip erase done");
		end_of_test();
	end
endmodule
`default_nettype wire
